/* logic/ams_pkg.sv */
// package: register map, field layout and states of the converter sequencer
package ams_pkg;

  // ==========================================================
  // register word addresses
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] SWEEP_ADDR  = 4'h1;
  localparam logic [3:0] STATUS_ADDR = 4'h2;
  localparam logic [3:0] MASK_ADDR   = 4'h3;
  localparam logic [3:0] RESULT_BASE = 4'h8;

  // ==========================================================
  // control register fields
  localparam int MODE_LSB  = 0;
  localparam int CHAN_LSB  = 2;
  localparam int TRIG_BIT  = 5;
  localparam int START_BIT = 6;

  // sweep register fields
  localparam int SCAN_LOW_BIT  = 0;
  localparam int SCAN_HIGH_BIT = 1;
  localparam int EMPH_BIT      = 2;

  // status and mask fields
  localparam int DONE_BIT = 0;

  // ==========================================================
  // reset values
  localparam logic [6:0] CTRL_RST   = 7'h00;
  localparam logic [2:0] SWEEP_RST  = 3'h0;
  localparam logic       STATUS_RST = 1'h0;
  localparam logic       MASK_RST   = 1'h0;

  // ==========================================================
  // conversion modes held in the mode field
  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'h0,
    MODE_REPEAT  = 2'h1,
    MODE_SWEEP   = 2'h2,
    MODE_RSWEEP0 = 2'h3
  } ams_mode_type;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_CONV = 3'b100
  } ams_state_type;

endpackage

/* logic/ams_sequencer.sv */
// module: mode sequencer for an eight-channel analog-to-digital converter
// Functional notes
// RQ1: one-shot mode converts only the selected channel, once per start.
// RQ2: writing 1 to the start flag begins conversion in the selected mode.
// RQ3: one-shot and single sweep self-clear the start flag unless triggered.
// RQ4: writing 0 to the start flag stops every mode; repeat modes end only so.
// RQ5: one-shot and single sweep raise an interrupt request when done.
// RQ6: repeat mode converts the selected channel until stopped, no interrupt.
// RQ7: single sweep converts a group of 2, 4, 6 or 8 channels from 0, once.
// RQ8: repeat sweep 0 sweeps the group continuously with no interrupt.
// RQ9: repeat sweep 1 cycles all channels, emphasised group between each one; the sequencer puts one emphasised channel, in turn, between each.
// RQ10: the emphasised group is 1 to 4 channels starting at channel zero.
// RQ11: one-shot and repeat convert the input chosen by channel select.
// RQ12: each result lands in its channel's result register, readable any time.
// RQ13: the two-bit group field means 2/4/6/8 channels, or 1/2/3/4 in sweep 1.
// RQ14: the emphasis bit at 1 selects repeat sweep 1, at 0 the other modes.
// RQ15: a result register changes only when its conversion has fully finished.
`timescale 1ns/1ps

module ams_sequencer #(
  parameter int DATA_W = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic [3:0]        regAddr,
  input  wire logic [15:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [15:0]       regRdata,
  input  wire logic              extTrig,
  output logic                   convStart,
  output logic      [2:0]        convChannel,
  input  wire logic              convDone,
  input  wire logic [DATA_W-1:0] convData,
  output logic                   irq
);

  // ==========================================================
  // helpers
  function automatic logic [2:0] sweepLast(input logic [1:0] scan);
    sweepLast = {scan, 1'b1};
  endfunction

  function automatic logic [2:0] emphLast(input logic [1:0] scan);
    emphLast = {1'b0, scan};
  endfunction

  // ==========================================================
  // state
  ams_pkg::ams_state_type   state_r;
  logic [1:0]               mode_r;
  logic [2:0]               chanSel_r;
  logic                     trigSel_r;
  logic                     startFlag_r;
  logic [1:0]               scan_r;
  logic                     emph_r;
  logic                     status_r;
  logic                     mask_r;
  logic [2:0]               curChan_r;
  logic                     emphTurn_r;
  logic [2:0]               emphPtr_r;
  logic [2:0]               otherPtr_r;
  logic [DATA_W-1:0]        result_r [8];
  logic                     trigS1_r;
  logic                     trigS2_r;
  logic                     trigS3_r;
  logic                     trigLevel_r;
  logic                     convStart_r;
  logic [2:0]               convChannel_r;
  logic [15:0]              regRdata_r;
  logic                     irq_r;

  // ==========================================================
  // decode
  logic ctrlWr;
  logic stopWr;
  logic isRs1;
  logic oneShot;
  logic singleSweep;
  logic trigEvent;
  logic convEnd;
  logic finish;
  logic [2:0] firstChan;
  logic [2:0] nextChan;

  assign ctrlWr  = regWr && (regAddr == ams_pkg::CTRL_ADDR);
  assign stopWr  = ctrlWr && !regWdata[ams_pkg::START_BIT];
  assign isRs1   = emph_r; // [RQ14]
  assign oneShot = !isRs1 && (mode_r == ams_pkg::MODE_ONESHOT);
  assign singleSweep = !isRs1 && (mode_r == ams_pkg::MODE_SWEEP);
  assign trigEvent = trigS2_r && trigS3_r && !trigLevel_r;
  assign convEnd = (state_r == ams_pkg::ST_CONV) && convDone && !stopWr;

  // single runs end after one channel or at the top of the group
  always_comb begin
    finish = 1'b0;
    if (oneShot) begin
      finish = 1'b1; // [RQ1]
    end else if (singleSweep) begin
      finish = (curChan_r == sweepLast(scan_r)); // [RQ7]
    end
  end

  always_comb begin
    if (isRs1 || mode_r[1]) begin
      firstChan = 3'h0;
    end else begin
      firstChan = chanSel_r; // [RQ11]
    end
  end

  // channel to convert after the current one
  always_comb begin
    nextChan = curChan_r;
    if (isRs1) begin
      if (emphTurn_r) begin
        nextChan = otherPtr_r; // [RQ9]
      end else if (emphPtr_r == emphLast(scan_r)) begin
        nextChan = 3'h0; // [RQ10]
      end else begin
        nextChan = emphPtr_r + 3'h1;
      end
    end else if (mode_r == ams_pkg::MODE_REPEAT) begin
      nextChan = chanSel_r; // [RQ6]
    end else if (mode_r[1]) begin
      if (curChan_r == sweepLast(scan_r)) begin
        nextChan = 3'h0; // [RQ8] [RQ13]
      end else begin
        nextChan = curChan_r + 3'h1;
      end
    end
  end

  // ==========================================================
  // trigger pin synchroniser and filter
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trigS1_r <= 1'b0;
      trigS2_r <= 1'b0;
      trigS3_r <= 1'b0;
      trigLevel_r <= 1'b0;
    end else if (ce) begin
      trigS1_r <= extTrig;
      trigS2_r <= trigS1_r;
      trigS3_r <= trigS2_r;
      if (trigS2_r == trigS3_r) begin
        trigLevel_r <= trigS3_r;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_r      <= ams_pkg::CTRL_RST[1:0];
      chanSel_r   <= ams_pkg::CTRL_RST[4:2];
      trigSel_r   <= ams_pkg::CTRL_RST[ams_pkg::TRIG_BIT];
      startFlag_r <= ams_pkg::CTRL_RST[ams_pkg::START_BIT];
    end else if (ce) begin
      if (ctrlWr) begin
        mode_r      <= regWdata[ams_pkg::MODE_LSB +: 2];
        chanSel_r   <= regWdata[ams_pkg::CHAN_LSB +: 3];
        trigSel_r   <= regWdata[ams_pkg::TRIG_BIT];
        startFlag_r <= regWdata[ams_pkg::START_BIT]; // [RQ2] [RQ4]
      end else if (convEnd && finish && !trigSel_r) begin
        startFlag_r <= 1'b0; // [RQ3]
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scan_r <= ams_pkg::SWEEP_RST[1:0];
      emph_r <= ams_pkg::SWEEP_RST[ams_pkg::EMPH_BIT];
    end else if (ce && regWr && (regAddr == ams_pkg::SWEEP_ADDR)) begin
      scan_r <= {regWdata[ams_pkg::SCAN_HIGH_BIT],
                 regWdata[ams_pkg::SCAN_LOW_BIT]};
      emph_r <= regWdata[ams_pkg::EMPH_BIT];
    end
  end

  // ==========================================================
  // interrupt status, mask and output
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      status_r <= ams_pkg::STATUS_RST;
      mask_r   <= ams_pkg::MASK_RST;
      irq_r    <= 1'b0;
    end else if (ce) begin
      // set wins over write-one-to-clear
      status_r <= (status_r && !(regWr && regAddr == ams_pkg::STATUS_ADDR
                   && regWdata[ams_pkg::DONE_BIT]))
                  || (convEnd && finish); // [RQ5]
      if (regWr && regAddr == ams_pkg::MASK_ADDR) begin
        mask_r <= regWdata[ams_pkg::DONE_BIT];
      end
      irq_r <= status_r && mask_r;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r       <= ams_pkg::ST_IDLE;
      curChan_r     <= 3'h0;
      emphTurn_r    <= 1'b0;
      emphPtr_r     <= 3'h0;
      otherPtr_r    <= 3'h0;
      convStart_r   <= 1'b0;
      convChannel_r <= 3'h0;
    end else if (ce) begin
      convStart_r <= 1'b0;
      unique case (state_r)
        ams_pkg::ST_IDLE: begin
          if (startFlag_r && !stopWr) begin
            curChan_r  <= firstChan;
            emphTurn_r <= 1'b1;
            emphPtr_r  <= 3'h0;
            otherPtr_r <= emphLast(scan_r) + 3'h1;
            if (trigSel_r) begin
              state_r <= ams_pkg::ST_ARM;
            end else begin
              state_r       <= ams_pkg::ST_CONV; // [RQ2]
              convStart_r   <= 1'b1;
              convChannel_r <= firstChan;
            end
          end
        end
        ams_pkg::ST_ARM: begin
          if (stopWr) begin
            state_r <= ams_pkg::ST_IDLE; // [RQ4]
          end else if (trigEvent) begin
            state_r       <= ams_pkg::ST_CONV;
            convStart_r   <= 1'b1;
            convChannel_r <= curChan_r;
          end
        end
        ams_pkg::ST_CONV: begin
          if (stopWr) begin
            state_r <= ams_pkg::ST_IDLE; // [RQ4]
          end else if (convDone) begin
            if (finish) begin
              curChan_r <= firstChan;
              state_r   <= trigSel_r ? ams_pkg::ST_ARM : ams_pkg::ST_IDLE;
            end else begin
              curChan_r     <= nextChan;
              convStart_r   <= 1'b1;
              convChannel_r <= nextChan;
            end
            if (isRs1) begin
              emphTurn_r <= !emphTurn_r;
              if (emphTurn_r) begin
                emphPtr_r <= nextChan == 3'h0 ? 3'h0 : emphPtr_r;
              end else begin
                emphPtr_r <= nextChan;
              end
              if (emphTurn_r) begin
                otherPtr_r <= (otherPtr_r == 3'h7)
                              ? emphLast(scan_r) + 3'h1
                              : otherPtr_r + 3'h1;
              end
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // result registers, written only on a finished conversion
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++) begin
        result_r[i] <= '0;
      end
    end else if (ce && convEnd) begin
      result_r[curChan_r] <= convData; // [RQ12] [RQ15]
    end
  end

  // ==========================================================
  // read port, data one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regRdata_r <= 16'h0000;
    end else if (ce) begin
      regRdata_r <= 16'h0000;
      if (regRd) begin
        if (regAddr[3]) begin
          regRdata_r <= 16'(result_r[regAddr[2:0]]); // [RQ12]
        end else begin
          unique case (regAddr)
            ams_pkg::CTRL_ADDR:
              regRdata_r <= {9'h000, startFlag_r, trigSel_r,
                             chanSel_r, mode_r};
            ams_pkg::SWEEP_ADDR:
              regRdata_r <= {13'h0000, emph_r, scan_r};
            ams_pkg::STATUS_ADDR:
              regRdata_r <= {15'h0000, status_r};
            ams_pkg::MASK_ADDR:
              regRdata_r <= {15'h0000, mask_r};
            default:
              regRdata_r <= 16'h0000;
          endcase
        end
      end
    end
  end

  assign regRdata    = regRdata_r;
  assign convStart   = convStart_r;
  assign convChannel = convChannel_r;
  assign irq         = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_start_issue: assert property ( // [RQ2]
    ce && state_r == ams_pkg::ST_IDLE && startFlag_r && !stopWr
    && !trigSel_r |=> convStart_r && state_r == ams_pkg::ST_CONV)
    else $error("start flag did not issue a conversion");

  chk_flag_autoclear: assert property ( // [RQ3]
    ce && convEnd && finish && !trigSel_r && !ctrlWr |=> !startFlag_r)
    else $error("start flag not cleared at end of single run");

  chk_stop_write: assert property ( // [RQ4]
    ce && stopWr |=> state_r == ams_pkg::ST_IDLE && !startFlag_r
    && !convStart_r)
    else $error("writing zero did not stop conversion");

  chk_done_irq: assert property ( // [RQ5]
    ce && convEnd && finish |=> status_r)
    else $error("completion did not set status");

  chk_repeat_no_irq: assert property ( // [RQ6]
    ce && convEnd && !oneShot && !singleSweep && !status_r |=> !status_r)
    else $error("repeating mode raised a completion request");

  chk_sweep_range: assert property ( // [RQ7]
    state_r == ams_pkg::ST_CONV && singleSweep
    |-> curChan_r <= sweepLast(scan_r))
    else $error("single sweep left its group");

  chk_rs1_emph: assert property ( // [RQ10]
    ce && convEnd && isRs1 && emphTurn_r
    |=> convStart_r && convChannel_r > emphLast(scan_r))
    else $error("emphasised channel not followed by another");

  chk_result_store: assert property ( // [RQ15]
    ce && convEnd |=> result_r[$past(curChan_r)] == $past(convData))
    else $error("result not stored for converted channel");

  chk_oneshot_chan: assert property ( // [RQ1]
    ce && state_r == ams_pkg::ST_IDLE && startFlag_r && !ctrlWr
    && oneShot && !trigSel_r |=> convChannel_r == $past(chanSel_r))
    else $error("one-shot converted the wrong channel");

  cov_oneshot_done: cover property (ce && convEnd && oneShot);
  cov_sweep_done:   cover property (ce && convEnd && singleSweep && finish);
  cov_rs1_run:      cover property (ce && convEnd && isRs1 && emphTurn_r);
  cov_trig_start:   cover property (
    ce && state_r == ams_pkg::ST_ARM && trigEvent);

endmodule

/* tb/ams_core_model.sv */
// conversion core stand-in: one done pulse per start, random result
`timescale 1ns/1ps

module ams_core_model (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       convStart,
  input  wire logic [3:0] lat,
  output logic            convDone,
  output logic [9:0]      convData
);
  logic [3:0] cnt;

  // ==========================================================
  // conversion timing
  always_ff @(posedge ref_clk) begin
    convDone <= 1'b0;
    convData <= ~convData;
    if (srst) begin
      cnt      <= 4'h0;
      convData <= 10'h155;
    end else if (convStart) begin
      cnt <= lat;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        convDone <= 1'b1;
        convData <= 10'($urandom);
      end
    end
  end

endmodule

/* tb/tb.sv */
// self-checking bench for the converter mode sequencer
`timescale 1ns/1ps

module tb;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] regRdata;
  logic        extTrig = 1'b0;
  logic        convStart;
  logic [2:0]  convChannel;
  logic        convDone;
  logic [9:0]  convData;
  logic        irq;
  logic [3:0]  lat = 4'h1;
  logic        rdPend = 1'b0;
  logic [15:0] lastData [8];
  logic [15:0] rdQ [$];
  logic [2:0]  chQ [$];
  int          nStart = 0;
  int          nDone = 0;
  int          miscompares = 0;
  int          samplesChecked = 0;

  always #12.5 ref_clk = ~ref_clk;

  ams_sequencer #(.DATA_W(10)) ams_sequencer_i (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .extTrig(extTrig), .convStart(convStart),
    .convChannel(convChannel), .convDone(convDone),
    .convData(convData), .irq(irq));

  ams_core_model ams_core_model_i (
    .ref_clk(ref_clk), .srst(srst), .convStart(convStart), .lat(lat),
    .convDone(convDone), .convData(convData));

  // ==========================================================
  // checking
  task giveVerdict;
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge ref_clk) begin
    if (rdPend && rdQ.size() != 0) begin
      check(regRdata, rdQ.pop_front());
    end
    rdPend <= regRd;
    if (convStart === 1'b1) begin
      nStart++;
      if (chQ.size() != 0) begin
        check(16'(convChannel), 16'(chQ.pop_front()));
      end else begin
        check(16'(convChannel), 16'hffff);
      end
    end
    if (convDone === 1'b1) begin
      nDone++;
      lastData[convChannel] <= {6'h0, convData};
    end
  end

  // ==========================================================
  // bus tasks
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [15:0] e);
    rdQ.push_back(e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
  endtask

  task settle;
    repeat (4) @(negedge ref_clk);
  endtask

  task waitN(input int n);
    for (int i = 0; i < 2000 && nDone < n; i++) @(negedge ref_clk);
    if (nDone < n) begin
      miscompares++;
      giveVerdict();
    end
  endtask

  // ==========================================================
  // mode runs: 0..3 mode field, 4 emphasis sweep
  function automatic logic [2:0] nextCh(int m, int g, int c, int k);
    int e;
    e = g + 1;
    if (m < 2) return 3'(c);
    if (m < 4) return 3'(k % (2 * e));
    if (k % 2 == 0) return 3'((k / 2) % e);
    return 3'(e + (k / 2) % (8 - e));
  endfunction

  task automatic go(int m, int g, int c, int n);
    int k;
    int t;
    int b;
    wr(ams_pkg::SWEEP_ADDR, 16'(g + ((m == 4) ? 4 : 0)));
    t = (m == 2) ? 2 * (g + 1) : n + 4;
    for (k = 0; k < t; k++) chQ.push_back(nextCh(m, g, c, k));
    b = nDone;
    lat <= 4'(1 + $urandom % 8);
    wr(ams_pkg::CTRL_ADDR, 16'((m % 4) + c * 4 + 64));
    waitN(b + ((m == 2) ? t : n));
    if (m != 2) wr(ams_pkg::CTRL_ADDR, 16'h0);
    settle();
    chQ.delete();
    if (m == 2) begin
      rd(ams_pkg::CTRL_ADDR, 16'(2 + c * 4));
      rd(ams_pkg::STATUS_ADDR, 16'h1);
      for (k = 0; k < t; k++)
        rd(ams_pkg::RESULT_BASE + 4'(k), lastData[k]);
      wr(ams_pkg::STATUS_ADDR, 16'h1);
    end else begin
      rd(ams_pkg::STATUS_ADDR, 16'h0);
      b = nStart;
      repeat (20) @(negedge ref_clk);
      check(16'(nStart), 16'(b));
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int c;
    int b;
    void'($urandom(21));
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rd(ams_pkg::CTRL_ADDR, 16'h0);
    rd(ams_pkg::SWEEP_ADDR, 16'h0);
    rd(ams_pkg::STATUS_ADDR, 16'h0);
    rd(ams_pkg::MASK_ADDR, 16'h0);
    rd(4'h4, 16'h0);
    rd(ams_pkg::RESULT_BASE, 16'h0);
    // frozen block ignores a write
    ce <= 1'b0;
    wr(ams_pkg::MASK_ADDR, 16'h1);
    ce <= 1'b1;
    rd(ams_pkg::MASK_ADDR, 16'h0);
    for (c = 0; c < 8; c++) begin
      lat <= 4'(1 + $urandom % 8);
      wr(ams_pkg::MASK_ADDR, 16'(c % 2));
      chQ.push_back(3'(c));
      b = nDone;
      wr(ams_pkg::CTRL_ADDR, 16'(c * 4 + 64));
      waitN(b + 1);
      settle();
      check({15'h0, irq}, 16'(c % 2));
      rd(ams_pkg::CTRL_ADDR, 16'(c * 4));
      rd(ams_pkg::STATUS_ADDR, 16'h1);
      rd(ams_pkg::RESULT_BASE + 4'(c), lastData[c]);
      wr(ams_pkg::STATUS_ADDR, 16'h1);
      settle();
      check({15'h0, irq}, 16'h0);
    end
    // trigger selected: armed, no start until the pin rises
    chQ.push_back(3'h2);
    b = nStart;
    wr(ams_pkg::CTRL_ADDR, 16'h68);
    repeat (10) @(negedge ref_clk);
    check(16'(nStart), 16'(b));
    b = nDone;
    @(posedge ref_clk);
    extTrig <= 1'b1;
    repeat (8) @(posedge ref_clk);
    extTrig <= 1'b0;
    waitN(b + 1);
    settle();
    rd(ams_pkg::CTRL_ADDR, 16'h68);
    rd(ams_pkg::STATUS_ADDR, 16'h1);
    wr(ams_pkg::CTRL_ADDR, 16'h0);
    wr(ams_pkg::STATUS_ADDR, 16'h1);
    go(1, 0, 5, 6);
    for (c = 0; c < 4; c++) go(2, c, 0, 0);
    go(3, 1, 0, 10);
    go(3, 3, 0, 10);
    go(4, 0, 0, 16);
    go(4, 3, 0, 12);
    giveVerdict();
  end
endmodule
